// ==== design/uetm_core.sv ====
// usb endpoint transaction manager: endpoint 0 control and endpoints 1-7 interrupt traffic
// How it works
// - error-free setup on endpoint 0 is stored, flag set, ACKed, setup interrupt raised.
// - while the request flag is set, endpoint 0 data/status get NAK regardless.
// - firmware halts both endpoint 0 directions for bad requests; device then STALLs.
// - clearing the setup interrupt also clears the request flag.
// - IN token with hold and halt clear sends packet; ACK toggles parity, sets hold, interrupts.
// - IN token gets NAK when hold set, STALL when halt set, no data.
// - no host handshake after IN data leaves parity and hold untouched for a resend.
// - good OUT data is stored, counted, parity toggled, hold set, ACKed, interrupt raised.
// - OUT with hold set gets NAK, with halt set STALL; buffer untouched.
// - OUT data with CRC or stuffing error gets no handshake.
// - control write status: firmware zeroes count, parity 1, clears hold; device sends empty DATA1.
// - control read status: firmware sets OUT endpoint 0 parity 1, clears hold; empty DATA1 accepted.
// - double-buffered OUT writes buffer X when parity 0, Y when parity 1.
// - double-buffered IN reads buffer X when parity 0, Y when parity 1.
// - double-buffered OUT keeps separate X and Y hold bits for firmware to inspect.
// - endpoints 1 to 7 in both directions serve as interrupt endpoints beside endpoint 0.
module uetm_core
  import uetm_pkg::*;
#(
  parameter int BUF_BYTES = DEF_BUF_BYTES
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // tokens from the serial engine
  input wire logic tokValid,
  input wire uetm_tok_type tokKind,
  input wire logic [2:0] tokEp,
  // received data stage bytes
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxDone,
  input wire logic rxErr,
  // handshake to the host
  output logic hsValid,
  output uetm_hs_type hsCode,
  // outgoing data packet
  output logic txStart,
  output logic txData1,
  output logic [$clog2(BUF_BYTES+1)-1:0] txLen,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  // host handshake after an IN packet
  input wire logic hostAck,
  input wire logic hostTimeout,
  // firmware configuration writes
  input wire logic fwCfgWr,
  input wire logic fwCfgDirIn,
  input wire logic [2:0] fwCfgEp,
  input wire uetm_fld_type fwCfgField,
  input wire logic [7:0] fwCfgData,
  // firmware buffer access
  input wire logic fwBufWr,
  input wire logic fwBufDirIn,
  input wire logic [2:0] fwBufEp,
  input wire logic fwBufY,
  input wire logic [$clog2(BUF_BYTES)-1:0] fwBufAddr,
  input wire logic [7:0] fwBufData,
  output logic [7:0] fwBufRdData,
  input wire logic [2:0] fwSetupAddr,
  output logic [7:0] fwSetupRdData,
  // firmware status view of the endpoint selected by fwCfgDirIn/fwCfgEp
  output logic fwRdHoldX,
  output logic fwRdHoldY,
  output logic fwRdParity,
  output logic fwRdHalt,
  output logic [$clog2(BUF_BYTES+1)-1:0] fwRdCountX,
  output logic [$clog2(BUF_BYTES+1)-1:0] fwRdCountY,
  // events and flags
  input wire logic fwSetupIrqClr,
  output logic ctrlRequest,
  output logic setupIrq,
  output logic epIrq,
  output logic [3:0] epIrqIdx
);

  localparam int CW = $clog2(BUF_BYTES+1);
  localparam int AW = $clog2(BUF_BYTES);
  localparam int MEM_WORDS = NUM_EP_SLOTS*2*BUF_BYTES;

  // buffers hold a setup packet, index cleanly, and their counts fit the 8-bit data field
  if (BUF_BYTES < SETUP_BYTES || BUF_BYTES > 128 || (BUF_BYTES & (BUF_BYTES-1)) != 0)
  begin : g_bad_buf
    $error("BUF_BYTES must be a power of two from 8 to 128");
  end

  typedef struct packed {
    uetm_state_type state;
    logic [15:0] enable, halt, holdX, holdY, parity, dbl, intEn;
    logic [15:0][CW-1:0] countX, countY;
    logic ctrlReq, setupIrq;
    logic [3:0] curIdx;
    logic curY, accept, discard, isSetup;
    logic [CW-1:0] byteIdx;
    logic hsValid;
    uetm_hs_type hsCode;
    logic txStart, txData1;
    logic [CW-1:0] txLen;
    logic [7:0] txByte;
    logic epIrq;
    logic [3:0] epIrqIdx;
    logic [7:0] bufRd, setupRd;
    logic rdHoldX, rdHoldY, rdParity, rdHalt;
    logic [CW-1:0] rdCountX, rdCountY;
  } uetm_core_state_type;

  uetm_core_state_type st_reg;
  uetm_core_state_type st_next;

  // packet storage lives outside the struct: it is a memory, not control state
  logic [7:0] bufMem [MEM_WORDS];
  logic [7:0] setupMem [SETUP_BYTES];

  // byte address of a buffer slot
  function automatic logic [$clog2(MEM_WORDS)-1:0] memAddr(input logic [3:0] idx,
      input logic y, input logic [AW-1:0] a);
    memAddr = {idx, y, a};
  endfunction

  logic [3:0] tokIdx;
  logic tokY;
  logic tokHold;
  logic rxWrite;
  logic [CW-1:0] nextIdx;

  assign tokIdx = {tokKind == TOK_IN, tokEp};
  // which half of a possibly double buffer the current parity selects
  assign tokY = st_reg.dbl[tokIdx] & st_reg.parity[tokIdx];
  assign tokHold = tokY ? st_reg.holdY[tokIdx] : st_reg.holdX[tokIdx];
  assign nextIdx = st_reg.byteIdx + CW'(1);
  assign rxWrite = st_reg.state == ST_RX && rxByteValid && st_reg.accept
    && !st_reg.isSetup && st_reg.byteIdx < CW'(BUF_BYTES);

  // next-state computation for every control register
  always_comb
  begin
    st_next = st_reg;
    st_next.hsValid = 1'b0;
    st_next.txStart = 1'b0;
    st_next.epIrq = 1'b0;

    // firmware configuration writes land first so hardware updates below win
    if (fwCfgWr)
    begin
      case (fwCfgField)
        FLD_ENABLE: st_next.enable[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_HALT: st_next.halt[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_HOLDX: st_next.holdX[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_HOLDY: st_next.holdY[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_PARITY: st_next.parity[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_DOUBLE: st_next.dbl[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_INTEN: st_next.intEn[{fwCfgDirIn, fwCfgEp}] = fwCfgData[0];
        FLD_COUNTX: st_next.countX[{fwCfgDirIn, fwCfgEp}] = fwCfgData[CW-1:0];
        FLD_COUNTY: st_next.countY[{fwCfgDirIn, fwCfgEp}] = fwCfgData[CW-1:0];
        default: st_next.enable = st_reg.enable;
      endcase
    end

    // clearing the setup interrupt drops the request flag too
    if (fwSetupIrqClr)
    begin
      st_next.setupIrq = 1'b0;
      st_next.ctrlReq = 1'b0;
    end

    case (st_reg.state)
      ST_IDLE:
      begin
        if (tokValid)
        begin
          st_next.curIdx = tokIdx;
          st_next.curY = tokY;
          st_next.byteIdx = '0;
          st_next.isSetup = tokKind == TOK_SETUP;
          st_next.accept = 1'b0;
          st_next.discard = 1'b0;
          st_next.hsCode = HS_ACK;
          if (!st_reg.enable[tokIdx])
          begin
            // disabled endpoint: swallow any data, answer nothing
            st_next.discard = 1'b1;
            st_next.state = tokKind == TOK_IN ? ST_IDLE : ST_RX;
          end
          else if (tokKind == TOK_SETUP)
          begin
            st_next.accept = tokEp == 3'h0;
            st_next.discard = tokEp != 3'h0;
            st_next.state = ST_RX;
          end
          else if (tokEp == 3'h0 && st_reg.ctrlReq)
          begin
            st_next.hsCode = HS_NAK;
            st_next.state = tokKind == TOK_IN ? ST_IDLE : ST_RX;
            st_next.hsValid = tokKind == TOK_IN;
          end
          else if (st_reg.halt[tokIdx] || tokHold)
          begin
            // halt outranks hold when both are set
            st_next.hsCode = st_reg.halt[tokIdx] ? HS_STALL : HS_NAK;
            st_next.state = tokKind == TOK_IN ? ST_IDLE : ST_RX;
            st_next.hsValid = tokKind == TOK_IN;
          end
          else if (tokKind == TOK_IN)
          begin
            // endpoints 1-7 run the same path as endpoint 0 data stages
            st_next.txStart = 1'b1;
            st_next.txData1 = st_reg.parity[tokIdx];
            st_next.txLen = tokY ? st_reg.countY[tokIdx] : st_reg.countX[tokIdx];
            st_next.txByte = bufMem[memAddr(tokIdx, tokY, '0)];
            st_next.state = (tokY ? st_reg.countY[tokIdx] : st_reg.countX[tokIdx]) == '0
              ? ST_WAIT : ST_TX;
          end
          else
          begin
            st_next.accept = 1'b1;
            st_next.state = ST_RX;
          end
        end
      end
      ST_RX:
      begin
        if (rxByteValid && st_reg.byteIdx < CW'(BUF_BYTES))
          st_next.byteIdx = nextIdx; // extra bytes beyond the buffer are dropped
        if (rxDone)
        begin
          st_next.state = ST_IDLE;
          // corrupted packets stay silent and leave counts, hold and parity as they were; their bytes still reach the buffer
          if (!rxErr && !st_reg.discard)
          begin
            st_next.hsValid = 1'b1;
            if (st_reg.isSetup)
            begin
              st_next.hsCode = HS_ACK;
              st_next.ctrlReq = 1'b1;
              st_next.setupIrq = 1'b1;
            end
            else if (st_reg.accept)
            begin
              if (st_reg.curY)
              begin
                st_next.countY[st_reg.curIdx] = st_reg.byteIdx;
                st_next.holdY[st_reg.curIdx] = 1'b1;
              end
              else
              begin
                st_next.countX[st_reg.curIdx] = st_reg.byteIdx;
                st_next.holdX[st_reg.curIdx] = 1'b1;
              end
              st_next.parity[st_reg.curIdx] = ~st_reg.parity[st_reg.curIdx];
              st_next.epIrq = st_reg.intEn[st_reg.curIdx];
              st_next.epIrqIdx = st_reg.curIdx;
            end
          end
        end
      end
      ST_TX:
      begin
        if (txReady)
        begin
          st_next.byteIdx = nextIdx;
          st_next.txByte = bufMem[memAddr(st_reg.curIdx, st_reg.curY, nextIdx[AW-1:0])];
          if (nextIdx == st_reg.txLen)
            st_next.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (hostAck)
        begin
          st_next.state = ST_IDLE;
          st_next.parity[st_reg.curIdx] = ~st_reg.parity[st_reg.curIdx];
          if (st_reg.curY)
            st_next.holdY[st_reg.curIdx] = 1'b1;
          else
            st_next.holdX[st_reg.curIdx] = 1'b1;
          st_next.epIrq = st_reg.intEn[st_reg.curIdx];
          st_next.epIrqIdx = st_reg.curIdx;
        end
        else if (hostTimeout)
        begin
          // lost handshake: same parity and hold, so the next IN resends it
          st_next.state = ST_IDLE;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase

    // firmware read view, one cycle behind its select inputs
    st_next.bufRd = bufMem[memAddr({fwBufDirIn, fwBufEp}, fwBufY, fwBufAddr)];
    st_next.setupRd = setupMem[fwSetupAddr];
    st_next.rdHoldX = st_reg.holdX[{fwCfgDirIn, fwCfgEp}];
    st_next.rdHoldY = st_reg.holdY[{fwCfgDirIn, fwCfgEp}];
    st_next.rdParity = st_reg.parity[{fwCfgDirIn, fwCfgEp}];
    st_next.rdHalt = st_reg.halt[{fwCfgDirIn, fwCfgEp}];
    st_next.rdCountX = st_reg.countX[{fwCfgDirIn, fwCfgEp}];
    st_next.rdCountY = st_reg.countY[{fwCfgDirIn, fwCfgEp}];
  end

  // control state register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.enable <= RST_ENABLE;
      st_reg.halt <= RST_HALT;
      st_reg.holdX <= RST_HOLD;
      st_reg.holdY <= RST_HOLD;
      st_reg.parity <= RST_PARITY;
      st_reg.dbl <= RST_DOUBLE;
      st_reg.intEn <= RST_INTEN;
      st_reg.hsCode <= HS_ACK;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // packet memories; the link side wins a clash since its bytes cannot be retried
  always_ff @(posedge clk_sys)
  begin
    if (rxWrite)
      bufMem[memAddr(st_reg.curIdx, st_reg.curY, st_reg.byteIdx[AW-1:0])] <= rxByte;
    else if (fwBufWr)
      bufMem[memAddr({fwBufDirIn, fwBufEp}, fwBufY, fwBufAddr)] <= fwBufData;
    if (st_reg.state == ST_RX && rxByteValid && st_reg.isSetup && st_reg.accept
      && st_reg.byteIdx < CW'(SETUP_BYTES))
      setupMem[st_reg.byteIdx[2:0]] <= rxByte;
  end

  // outputs
  assign hsValid = st_reg.hsValid;
  assign hsCode = st_reg.hsCode;
  assign txStart = st_reg.txStart;
  assign txData1 = st_reg.txData1;
  assign txLen = st_reg.txLen;
  assign txValid = st_reg.state == ST_TX; // handshake, may be combinational
  assign txByte = st_reg.txByte;
  assign fwBufRdData = st_reg.bufRd;
  assign fwSetupRdData = st_reg.setupRd;
  assign fwRdHoldX = st_reg.rdHoldX;
  assign fwRdHoldY = st_reg.rdHoldY;
  assign fwRdParity = st_reg.rdParity;
  assign fwRdHalt = st_reg.rdHalt;
  assign fwRdCountX = st_reg.rdCountX;
  assign fwRdCountY = st_reg.rdCountY;
  assign ctrlRequest = st_reg.ctrlReq;
  assign setupIrq = st_reg.setupIrq;
  assign epIrq = st_reg.epIrq;
  assign epIrqIdx = st_reg.epIrqIdx;

endmodule // uetm_core

// ==== design/uetm_pkg.sv ====
// shared constants and types for the usb endpoint transaction manager
package uetm_pkg;

  // endpoint space: 8 numbers in each direction, index = {dirIn, number}
  localparam int NUM_EP = 8;
  localparam int NUM_EP_SLOTS = 16;
  localparam int SETUP_BYTES = 8;
  localparam int DEF_BUF_BYTES = 8;

  // values after reset
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_HALT = 16'h0000;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic [15:0] RST_PARITY = 16'h0000;
  localparam logic [15:0] RST_DOUBLE = 16'h0000;
  localparam logic [15:0] RST_INTEN = 16'h0000;

  // token kinds reported by the serial engine
  typedef enum logic [1:0] {
    TOK_OUT = 2'h0,
    TOK_IN = 2'h1,
    TOK_SETUP = 2'h2
  } uetm_tok_type;

  // handshake answers sent back to the host
  typedef enum logic [1:0] {
    HS_ACK = 2'h0,
    HS_NAK = 2'h1,
    HS_STALL = 2'h2
  } uetm_hs_type;

  // configuration fields firmware can write
  typedef enum logic [3:0] {
    FLD_ENABLE = 4'h0,
    FLD_HALT = 4'h1,
    FLD_HOLDX = 4'h2,
    FLD_HOLDY = 4'h3,
    FLD_PARITY = 4'h4,
    FLD_DOUBLE = 4'h5,
    FLD_INTEN = 4'h6,
    FLD_COUNTX = 4'h7,
    FLD_COUNTY = 4'h8
  } uetm_fld_type;

  // transaction sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_TX = 2'b10,
    ST_WAIT = 2'b11
  } uetm_state_type;

endpackage : uetm_pkg

// ==== verification/uetm_checker.sv ====
// port checker for the usb endpoint transaction manager
module uetm_checker
  import uetm_pkg::*;
#(
  parameter int BUF_BYTES = DEF_BUF_BYTES
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // host side
  input wire logic tokValid,
  input wire uetm_tok_type tokKind,
  input wire logic [2:0] tokEp,
  input wire logic rxDone,
  input wire logic rxErr,
  input wire logic hsValid,
  input wire uetm_hs_type hsCode,
  input wire logic txStart,
  input wire logic [$clog2(BUF_BYTES+1)-1:0] txLen,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic txReady,
  input wire logic hostTimeout,
  // firmware side
  input wire logic fwSetupIrqClr,
  input wire logic ctrlRequest,
  input wire logic setupIrq,
  input wire logic epIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // a setup packet is in flight towards endpoint 0
  logic setupPend_reg;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      setupPend_reg <= 1'b0;
    else if (tokValid)
      setupPend_reg <= tokKind == TOK_SETUP && tokEp == 3'h0;
    else if (rxDone)
      setupPend_reg <= 1'b0;
  end

  sequence sGoodSetup;
    rxDone && !rxErr && setupPend_reg;
  endsequence
  sequence sSetupAck;
    hsValid && hsCode == HS_ACK && ctrlRequest && setupIrq;
  endsequence

  // a disabled endpoint 0 stays silent, so only an answer is judged here
  chk_setup_flag: assert property (sGoodSetup |=> (!hsValid) or sSetupAck)
    else $error("setup answered without ack or flags");
  chk_clr_flags: assert property (fwSetupIrqClr && !rxDone |=> !ctrlRequest && !setupIrq)
    else $error("setup flags survived the clear");
  chk_flag_nak: assert property (ctrlRequest && tokValid && tokKind == TOK_IN && tokEp == 3'h0
    |=> !txStart && (!hsValid || hsCode == HS_NAK))
    else $error("endpoint 0 served while request pending");
  chk_crc_quiet: assert property (rxDone && rxErr |=> !hsValid)
    else $error("handshake after damaged packet");
  chk_in_noack: assert property (tokValid && tokKind == TOK_IN |=> !(hsValid && hsCode == HS_ACK))
    else $error("device acked an in token");
  chk_empty_len: assert property (txStart |-> txValid == (txLen != '0))
    else $error("data beats disagree with length");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("tx byte moved while stalled");
  chk_timeout_keep: assert property (hostTimeout |=> !epIrq && !txStart)
    else $error("timeout treated as delivery");
endmodule // uetm_checker

bind uetm_core uetm_checker #(.BUF_BYTES(BUF_BYTES)) chkInst (.*);

// ==== verification/uetm_host_model.sv ====
// host and serial engine model: tokens, out packets, in packet intake
module uetm_host_model
  import uetm_pkg::*;
#(
  parameter int CW = 4
)(
  // clock
  input wire logic clk_sys,
  // requests towards the device
  output logic tokValid,
  output uetm_tok_type tokKind,
  output logic [2:0] tokEp,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxDone,
  output logic rxErr,
  output logic txReady,
  output logic hostAck,
  output logic hostTimeout,
  // answers from the device
  input wire logic hsValid,
  input wire uetm_hs_type hsCode,
  input wire logic txStart,
  input wire logic txData1,
  input wire logic [CW-1:0] txLen,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic epIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pay [0:7];
  logic [7:0] flip;
  logic [7:0] got [$];
  logic [2:0] hsGot;
  logic startSeen, d1Got, irqSeen;
  logic [CW-1:0] lenGot;

  // idle bus at time zero
  initial
  begin
    {tokValid, rxByteValid, rxDone, rxErr, txReady, hostAck, hostTimeout} = 7'h00;
    tokKind = TOK_OUT;
    tokEp = 3'h0;
    rxByte = 8'h00;
    flip = 8'h00;
  end

  // one whole transaction, results kept for the bench
  task automatic xact(input uetm_tok_type k, input logic [2:0] ep, input int n,
    input logic err, input logic ack);
    int g;
    g = 0;
    got.delete();
    irqSeen = 1'b0;
    @(posedge clk_sys);
    tokValid <= 1'b1;
    tokKind <= k;
    tokEp <= ep;
    @(posedge clk_sys);
    tokValid <= 1'b0;
    if (k == TOK_IN)
    begin
      #1;
      hsGot = {hsValid, hsCode};
      startSeen = txStart;
      d1Got = txData1;
      lenGot = txLen;
      while (startSeen && got.size() < lenGot && g < 100)
      begin
        @(posedge clk_sys);
        g++;
        txReady <= g[0];  // takes every other beat, so the device sees stalls
        #1;
        if (txValid && txReady)
          got.push_back(txByte);
      end
      if (startSeen)
      begin
        @(posedge clk_sys);
        txReady <= 1'b0;
        hostAck <= ack;
        hostTimeout <= !ack;
        @(posedge clk_sys);
        hostAck <= 1'b0;
        hostTimeout <= 1'b0;
        #1;
        irqSeen = epIrq;
      end
    end
    else
    begin
      for (int i = 0; i < n; i++)
      begin
        rxByteValid <= 1'b1;
        rxByte <= pay[i] ^ flip;  // n of 0 gives the empty status packet
        @(posedge clk_sys);
      end
      rxByteValid <= 1'b0;
      rxByte <= ~rxByte;  // released line must not keep the last byte
      rxDone <= 1'b1;
      rxErr <= err;
      @(posedge clk_sys);
      rxDone <= 1'b0;
      rxErr <= 1'b0;
      #1;
      hsGot = {hsValid, hsCode};
      irqSeen = epIrq;
    end
  endtask
endmodule // uetm_host_model

// ==== verification/testbench.sv ====
// self-checking bench for the usb endpoint transaction manager
module testbench
  import uetm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BB = 8;
  localparam int CW = $clog2(BB + 1);
  localparam int AW = $clog2(BB);
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  logic clk_sys, nrst, tokValid, rxByteValid, rxDone, rxErr, txReady, hostAck, hostTimeout;
  logic hsValid, txStart, txData1, txValid, fwCfgWr, fwCfgDirIn, fwBufWr, fwBufDirIn, fwBufY;
  logic fwRdHoldX, fwRdHoldY, fwRdParity, fwRdHalt, fwSetupIrqClr, ctrlRequest, setupIrq, epIrq;
  logic [2:0] tokEp, fwCfgEp, fwBufEp, fwSetupAddr, e;
  logic [7:0] rxByte, txByte, fwCfgData, fwBufData, fwBufRdData, fwSetupRdData;
  logic [CW-1:0] txLen, fwRdCountX, fwRdCountY;
  logic [AW-1:0] fwBufAddr;
  logic [3:0] epIrqIdx;
  logic [1:0] r;
  uetm_tok_type tokKind;
  uetm_hs_type hsCode;
  uetm_fld_type fwCfgField;
  int errors, n_compared, seed, n;

  uetm_core #(.BUF_BYTES(BB)) dut (.*);
  uetm_host_model #(.CW(CW)) host (.*);

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard, far beyond the thousand or so cycles the run needs
  initial
  begin
    #100us;
    errors++;
    complete_run();
  end

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one configuration write pulse
  task automatic cfg(input logic d, input logic [2:0] ep, input uetm_fld_type f,
    input logic [7:0] v);
    @(posedge clk_sys);
    fwCfgWr <= 1'b1;
    fwCfgDirIn <= d;
    fwCfgEp <= ep;
    fwCfgField <= f;
    fwCfgData <= v;
    @(posedge clk_sys);
    fwCfgWr <= 1'b0;
  endtask

  // endpoint set up the way firmware does before use
  task automatic prep(input logic d, input logic [2:0] ep, input logic dbl, input logic p,
    input logic h);
    cfg(d, ep, FLD_ENABLE, 8'h01);
    cfg(d, ep, FLD_INTEN, 8'h01);
    cfg(d, ep, FLD_DOUBLE, {7'h00, dbl});
    cfg(d, ep, FLD_PARITY, {7'h00, p});
    cfg(d, ep, FLD_HOLDX, {7'h00, h});
    cfg(d, ep, FLD_HOLDY, {7'h00, h});
    cfg(d, ep, FLD_HALT, 8'h00);
  endtask

  // status view lags its selection by one register stage
  task automatic look(input logic d, input logic [2:0] ep, input logic hx, input logic hy,
    input logic p, input logic b, input int cnt);
    @(posedge clk_sys);
    fwCfgDirIn <= d;
    fwCfgEp <= ep;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({fwRdHoldX, fwRdHoldY, fwRdParity, fwRdHalt}, {hx, hy, p, 1'b0})
    `CHK(b ? fwRdCountY : fwRdCountX, cnt[CW-1:0])
  endtask

  // buffer or setup bytes read back against the payload
  task automatic rdback(input logic [2:0] ep, input logic y, input int cnt, input logic s);
    for (int i = 0; i < cnt; i++)
    begin
      @(posedge clk_sys);
      fwBufDirIn <= 1'b0;
      fwBufEp <= ep;
      fwBufY <= y;
      fwBufAddr <= i[AW-1:0];
      fwSetupAddr <= i[2:0];
      @(posedge clk_sys);
      #1;
      `CHK(s ? fwSetupRdData : fwBufRdData, host.pay[i])
    end
  endtask

  // in buffer filled, then counted
  task automatic load(input logic [2:0] ep, input logic y, input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      @(posedge clk_sys);
      fwBufWr <= 1'b1;
      fwBufDirIn <= 1'b1;
      fwBufEp <= ep;
      fwBufY <= y;
      fwBufAddr <= i[AW-1:0];
      fwBufData <= host.pay[i];
    end
    @(posedge clk_sys);
    fwBufWr <= 1'b0;
    cfg(1'b1, ep, y ? FLD_COUNTY : FLD_COUNTX, 8'(cnt));
  endtask

  task automatic inRound(input logic [2:0] ep, input logic dbl, input logic p, input int cnt);
    logic b;
    b = dbl & p;
    prep(1'b1, ep, dbl, p, 1'b1);
    host.xact(TOK_IN, ep, 0, 1'b0, 1'b0);
    `CHK(host.hsGot, {1'b1, HS_NAK})
    cfg(1'b1, ep, FLD_HALT, 8'h01);
    host.xact(TOK_IN, ep, 0, 1'b0, 1'b0);
    `CHK(host.hsGot, {1'b1, HS_STALL})
    cfg(1'b1, ep, FLD_HALT, 8'h00);
    load(ep, b, cnt);
    cfg(1'b1, ep, b ? FLD_HOLDY : FLD_HOLDX, 8'h00);
    // first pass times out, the resend must be identical
    for (int a = 0; a < 2; a++)
    begin
      host.xact(TOK_IN, ep, 0, 1'b0, a[0]);
      `CHK({host.startSeen, host.d1Got, host.lenGot}, {1'b1, p, cnt[CW-1:0]})
      for (int i = 0; i < cnt; i++)
        `CHK(host.got[i], host.pay[i])
      `CHK(host.irqSeen, a[0])
    end
    `CHK(epIrqIdx, {1'b1, ep})
    look(1'b1, ep, 1'b1, 1'b1, !p, b, cnt);
  endtask

  task automatic outRound(input logic [2:0] ep, input logic dbl, input logic p, input int cnt);
    logic b;
    b = dbl & p;
    prep(1'b0, ep, dbl, p, 1'b0);
    host.xact(TOK_OUT, ep, cnt, 1'b1, 1'b0);
    `CHK(host.hsGot[2], 1'b0)
    host.xact(TOK_OUT, ep, cnt, 1'b0, 1'b0);
    `CHK({host.hsGot, host.irqSeen}, {1'b1, HS_ACK, 1'b1})
    `CHK(epIrqIdx, {1'b0, ep})
    if (dbl)
    begin
      host.xact(TOK_OUT, ep, cnt, 1'b0, 1'b0);
      `CHK(host.hsGot, {1'b1, HS_ACK})
    end
    host.flip = 8'hff;
    host.xact(TOK_OUT, ep, cnt, 1'b0, 1'b0);
    host.flip = 8'h00;
    `CHK(host.hsGot, {1'b1, HS_NAK})
    look(1'b0, ep, 1'b1, dbl, p ^ !dbl, b, cnt);
    rdback(ep, b, cnt, 1'b0);
  endtask

  // main sequence
  initial
  begin
    seed = 32'h3acc7e91;
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    {fwCfgWr, fwCfgDirIn, fwBufWr, fwBufDirIn, fwBufY, fwSetupIrqClr} = 6'h00;
    {fwCfgEp, fwBufEp, fwSetupAddr, fwBufAddr} = '0;
    {fwCfgData, fwBufData} = 16'h0000;
    fwCfgField = FLD_ENABLE;
    foreach (host.pay[i])
      host.pay[i] = 8'($random(seed));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    prep(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
    prep(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
    host.xact(TOK_SETUP, 3'h0, 8, 1'b0, 1'b0);
    `CHK({host.hsGot, ctrlRequest, setupIrq}, {1'b1, HS_ACK, 2'b11})
    rdback(3'h0, 1'b0, 8, 1'b1);
    // rejected request: halt both directions, pending flag still wins
    cfg(1'b1, 3'h0, FLD_HALT, 8'h01);
    cfg(1'b0, 3'h0, FLD_HALT, 8'h01);
    host.xact(TOK_IN, 3'h0, 0, 1'b0, 1'b0);
    `CHK(host.hsGot, {1'b1, HS_NAK})
    host.xact(TOK_OUT, 3'h0, 2, 1'b0, 1'b0);
    `CHK(host.hsGot, {1'b1, HS_NAK})
    @(posedge clk_sys);
    fwSetupIrqClr <= 1'b1;
    @(posedge clk_sys);
    fwSetupIrqClr <= 1'b0;
    #1;
    `CHK({ctrlRequest, setupIrq}, 2'b00)
    host.xact(TOK_OUT, 3'h0, 2, 1'b0, 1'b0);
    `CHK(host.hsGot, {1'b1, HS_STALL})
    inRound(3'h0, 1'b0, 1'b1, 8);
    inRound(3'h0, 1'b0, 1'b1, 0);
    outRound(3'h0, 1'b0, 1'b1, 0);
    repeat (6)
    begin
      e = 3'(1 + {$random(seed)} % 7);
      n = {$random(seed)} % 9;
      r = 2'($random(seed));
      foreach (host.pay[i])
        host.pay[i] = 8'($random(seed));
      inRound(e, r[0], r[1], n);
      outRound(e, r[0], r[1], n);
      cfg(1'b1, e, FLD_ENABLE, 8'h00);
      host.xact(TOK_IN, e, 0, 1'b0, 1'b0);
      `CHK({host.hsGot[2], host.startSeen}, 2'b00)
    end
    complete_run();
  end
endmodule // testbench
